/* File: rtcto_defines.svh */
// Purpose: constants of the trim scheduler and square wave output
// Assumes: included by every design file of the block except the package
// Notes:   definitions only
`ifndef RTCTO_DEFINES_SVH
`define RTCTO_DEFINES_SVH

// prescaler layout
`define RTCTO_PRE_W        15
`define RTCTO_TRIM_STAGE   5
`define RTCTO_TAP_64HZ     8
`define RTCTO_TAP_1HZ      14

// square wave select codes
`define RTCTO_SEL_32K      3'h0
`define RTCTO_SEL_16K      3'h1
`define RTCTO_SEL_8K       3'h2
`define RTCTO_SEL_4K       3'h3
`define RTCTO_SEL_2K       3'h4
`define RTCTO_SEL_1K       3'h5
`define RTCTO_SEL_1HZ      3'h6
`define RTCTO_SEL_OFF      3'h7

// trim schedule
`define RTCTO_SEC_LAST     6'h3B
`define RTCTO_MAG_LINEAR   7'h3C
`define RTCTO_MIN_LAST     7'h77
`define RTCTO_FAST_MASK    7'h03
`define RTCTO_NORMAL_SLOTS 7'h3C

// reset values
`define RTCTO_RST_SECOND   6'h00
`define RTCTO_RST_MINUTE   7'h00
`define RTCTO_RST_PEND     3'h0

`endif

/* File: rtcto_pkg.sv */
// Purpose: types shared by the trim and square wave logic
// Assumes: constants come from rtcto_defines.svh
// Notes:   control bits arrive as one packed struct
package rtcto_pkg;

  // software-visible control bits, held outside this block
  typedef struct packed {
    logic       trim_fast;
    logic [6:0] trim_value;
    logic       trim_irq_enable;
    logic [2:0] square_wave_pin_rate_select;
    logic       square_wave_output_enable;
    logic       time_halt;
  } rtcto_ctrl_t;

  // time base position inside the trim cycle
  typedef struct packed {
    logic [6:0] minute;
    logic [5:0] second;
  } rtcto_time_t;

  // trim pulse burst sequencer
  typedef enum logic [0:0] {
    RTCTO_BST_IDLE = 1'b0,
    RTCTO_BST_GAP  = 1'b1
  } rtcto_burst_t;

endpackage : rtcto_pkg

/* File: rtcto_prescaler.sv */
// Purpose: oscillator divider chain with halt reset and trim steps
// Assumes: osc_rise_i is a one-cycle pulse per oscillator period
// Notes:   trim acts on the upper stages only
`timescale 1ns/10ps
`include "rtcto_defines.svh"
module rtcto_prescaler
  import rtcto_pkg::*;
#(
  parameter int W     = `RTCTO_PRE_W,
  parameter int LOW_W = `RTCTO_TRIM_STAGE
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         osc_rise_i,
  input  wire logic         halt_i,
  input  wire logic         trim_step_i,
  input  wire logic         trim_neg_i,
  output logic [W-1:0]      stage_o
);
  localparam int UP_W = W - LOW_W;

  logic [W-1:0]    stage;
  logic [W-1:0]    next_stage;
  logic [LOW_W-1:0] low;
  logic [UP_W-1:0]  upper;
  logic [UP_W-1:0]  upper_step;

  // binary ripple equivalent: each low bit is a clean divide-by-two, so
  // the low taps are 50:50; a trim step skips or repeats one upper count
  always_comb begin
    low        = stage[LOW_W-1:0];
    upper      = stage[W-1:LOW_W];
    upper_step = upper + {{(UP_W-1){1'b0}}, &low};
    next_stage = stage;
    if (osc_rise_i) begin
      // a trim step adds or swallows one upper count; low taps untouched
      if (trim_step_i) begin
        upper_step = trim_neg_i ? upper_step - 1'b1 : upper_step + 1'b1;
      end
      next_stage = {upper_step, LOW_W'(low + 1'b1)};
    end
    // halt clears F2 upward, F0/F1 keep counting
    if (halt_i) begin
      next_stage = {{(W-2){1'b0}}, 2'(stage[1:0] + {1'b0, osc_rise_i})};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage <= '0;
    end else begin
      stage <= next_stage;
    end
  end

  assign stage_o = stage;

  chk_trim_low_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (osc_rise_i && trim_step_i && !halt_i) |=> stage[LOW_W-1:0] == LOW_W'($past(stage[LOW_W-1:0]) + 1'b1))
    else $error("trim step disturbed the low prescaler stages");

  chk_halt_upper_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    halt_i |=> (stage[W-1:2] == '0))
    else $error("upper prescaler not held during halt");

endmodule : rtcto_prescaler

/* File: rtcto_trim_square_wave_pin.sv */
// Purpose: trim pulse scheduler and programmable square wave output
// Assumes: osc_32k_i is the oscillator level, synchronous to clk_i
// Notes:   ctrl_i is driven by the register file outside this block
`timescale 1ns/10ps
`include "rtcto_defines.svh"
module rtcto_trim_square_wave_pin
  import rtcto_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         osc_32k_i,
  input  wire rtcto_ctrl_t  ctrl_i,
  output logic              square_wave_pin_o,
  output logic              trim_irq_n_o,
  output logic              second_tick_o,
  output logic              timer_64hz_o
);

  // two's complement trim value to pulse count, -64 gives 64
  function automatic logic [6:0] trim_magnitude(input logic [6:0] v);
    trim_magnitude = v[6] ? 7'((~v) + 7'h01) : v;
  endfunction : trim_magnitude

  // pulses owed in one slot of the trim cycle
  function automatic logic [2:0] slot_pulses(input logic [6:0] mag, input logic [5:0] slot);
    if (slot < `RTCTO_SEC_LAST) begin
      slot_pulses = ({1'b0, slot} < mag) ? 3'h1 : 3'h0;
    end else if (slot == `RTCTO_SEC_LAST && mag >= `RTCTO_MAG_LINEAR) begin
      slot_pulses = 3'(mag - {1'b0, `RTCTO_SEC_LAST});
    end else begin
      slot_pulses = 3'h0;
    end
  endfunction : slot_pulses

  logic [`RTCTO_PRE_W-1:0] stage;
  logic                    osc_prev;
  logic                    f14_prev;
  rtcto_time_t             tm;
  logic                    next_osc_prev;
  logic                    next_f14_prev;
  rtcto_time_t             next_tm;
  logic                    osc_rise;
  logic                    second_tick;
  logic                    sched_fire;
  logic [5:0]              slot;
  logic [6:0]              mag;
  logic [2:0]              sched_count;

  // time base: seconds and a two-hour minute count follow the trimmed 1 Hz
  always_comb begin
    osc_rise      = osc_32k_i && !osc_prev;
    second_tick   = stage[`RTCTO_TAP_1HZ] && !f14_prev;
    next_osc_prev = osc_32k_i;
    next_f14_prev = stage[`RTCTO_TAP_1HZ];
    next_tm       = tm;
    if (second_tick) begin
      if (tm.second == `RTCTO_SEC_LAST) begin
        next_tm.second = `RTCTO_RST_SECOND;
        next_tm.minute = (tm.minute == `RTCTO_MIN_LAST) ? `RTCTO_RST_MINUTE : 7'(tm.minute + 7'h01);
      end else begin
        next_tm.second = 6'(tm.second + 6'h01);
      end
    end
    mag = trim_magnitude(ctrl_i.trim_value);
    // fast: slots are seconds of every fourth minute; normal: minutes
    if (ctrl_i.trim_fast) begin
      slot       = next_tm.second;
      sched_fire = second_tick && ((next_tm.minute & `RTCTO_FAST_MASK) == 7'h00);
    end else begin
      slot       = next_tm.minute[5:0];
      sched_fire = second_tick && (next_tm.second == `RTCTO_RST_SECOND) &&
                   (next_tm.minute < `RTCTO_NORMAL_SLOTS);
    end
    sched_count = slot_pulses(mag, slot); // zero magnitude owes nothing
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_prev <= 1'b0;
      f14_prev <= 1'b0;
      tm       <= '{minute: `RTCTO_RST_MINUTE, second: `RTCTO_RST_SECOND};
    end else begin
      osc_prev <= next_osc_prev;
      f14_prev <= next_f14_prev;
      tm       <= next_tm;
    end
  end

  rtcto_burst_t burst_state;
  rtcto_burst_t next_burst_state;
  logic [2:0]   pend;
  logic [2:0]   next_pend;
  logic         trim_step;

  // burst sequencer: steps land on carries out of the low stages, at least
  // one oscillator period apart, so the interrupt line gets a low and a
  // high phase for each step
  always_comb begin
    next_burst_state = burst_state;
    next_pend        = pend;
    // never step on a load cycle, otherwise a step would be counted twice;
    // stepping only on a carry makes a removal swallow a count instead of
    // running the upper stages backwards across a second boundary
    trim_step        = osc_rise && (&stage[`RTCTO_TRIM_STAGE-1:0]) && !second_tick &&
                       (burst_state == RTCTO_BST_IDLE) && (pend != 3'h0);
    case (burst_state)
      RTCTO_BST_IDLE: begin
        if (trim_step) begin
          next_pend        = 3'(pend - 3'h1);
          next_burst_state = RTCTO_BST_GAP;
        end
      end
      RTCTO_BST_GAP: begin
        if (osc_rise) begin
          next_burst_state = RTCTO_BST_IDLE;
        end
      end
      default: begin
        next_burst_state = RTCTO_BST_IDLE;
      end
    endcase
    if (sched_fire) begin
      next_pend = sched_count;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      burst_state <= RTCTO_BST_IDLE;
      pend        <= `RTCTO_RST_PEND;
    end else begin
      burst_state <= next_burst_state;
      pend        <= next_pend;
    end
  end

  // divider chain; sign of the trim value picks insert or remove
  rtcto_prescaler #(
    .W     (`RTCTO_PRE_W),
    .LOW_W (`RTCTO_TRIM_STAGE)
  ) u_prescaler (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .osc_rise_i  (osc_rise),
    .halt_i      (ctrl_i.time_halt),
    .trim_step_i (trim_step),
    .trim_neg_i  (ctrl_i.trim_value[6]),
    .stage_o     (stage)
  );

  logic clk_src;
  logic halt_gated;
  logic next_square;
  logic next_irq_n;
  logic next_tick_o;
  logic next_64hz;

  // output stage: everything registered so the pin never glitches
  always_comb begin
    halt_gated = 1'b0;
    case (ctrl_i.square_wave_pin_rate_select)
      `RTCTO_SEL_32K: clk_src = osc_prev; // oscillator itself, duty not guaranteed
      `RTCTO_SEL_16K: clk_src = stage[0];
      `RTCTO_SEL_8K:  clk_src = stage[1];
      `RTCTO_SEL_4K: begin
        clk_src    = stage[2];
        halt_gated = 1'b1;
      end
      `RTCTO_SEL_2K: begin
        clk_src    = stage[3];
        halt_gated = 1'b1;
      end
      `RTCTO_SEL_1K: begin
        clk_src    = stage[4];
        halt_gated = 1'b1;
      end
      `RTCTO_SEL_1HZ: begin
        clk_src    = stage[`RTCTO_TAP_1HZ]; // trimmed tap
        halt_gated = 1'b1;
      end
      default: clk_src = 1'b0; // select off
    endcase
    next_square = clk_src && ctrl_i.square_wave_output_enable &&
                  !(halt_gated && ctrl_i.time_halt);
    next_irq_n  = !((next_burst_state == RTCTO_BST_GAP) && ctrl_i.trim_irq_enable);
    next_tick_o = second_tick;
    next_64hz   = stage[`RTCTO_TAP_64HZ];
  end

  // pin is push-pull and follows the select from reset onward
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      square_wave_pin_o <= 1'b0;
      trim_irq_n_o      <= 1'b1;
      second_tick_o     <= 1'b0;
      timer_64hz_o      <= 1'b0;
    end else begin
      square_wave_pin_o <= next_square;
      trim_irq_n_o      <= next_irq_n;
      second_tick_o     <= next_tick_o;
      timer_64hz_o      <= next_64hz;
    end
  end

  sequence seq_burst_apply;
    (burst_state == RTCTO_BST_IDLE) && trim_step;
  endsequence

  sequence seq_step_taken;
    (burst_state == RTCTO_BST_GAP) && (pend == 3'($past(pend) - 3'h1));
  endsequence

  chk_burst_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    seq_burst_apply |=> seq_step_taken)
    else $error("trim step did not consume one pending pulse");

  chk_irq_per_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (trim_step && ctrl_i.trim_irq_enable) |=> !trim_irq_n_o)
    else $error("no interrupt pulse for an applied trim step");

  chk_irq_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ctrl_i.trim_irq_enable |=> trim_irq_n_o)
    else $error("interrupt pulse while trim interrupt disabled");

  chk_zero_trim: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sched_fire && (mag == 7'h00)) |=> (pend == 3'h0))
    else $error("pulses scheduled for zero trim");

  chk_linear_slot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sched_fire && ctrl_i.trim_fast && (slot < `RTCTO_SEC_LAST)) |=>
    (pend == (({1'b0, $past(slot)} < $past(mag)) ? 3'h1 : 3'h0)))
    else $error("wrong pulse count in a linear second");

  chk_last_second: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sched_fire && ctrl_i.trim_fast && (slot == `RTCTO_SEC_LAST) && (mag > `RTCTO_MAG_LINEAR)) |=>
    (pend == 3'($past(mag) - 7'h3B)))
    else $error("wrong remainder burst in second 59");

  chk_fast_cycle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (second_tick && ctrl_i.trim_fast && (next_tm.minute[1:0] != 2'h0)) |=> (pend == $past(pend)))
    else $error("trim scheduled outside the four-minute cycle");

  chk_off_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((ctrl_i.square_wave_pin_rate_select == `RTCTO_SEL_OFF) || !ctrl_i.square_wave_output_enable) |=>
    !square_wave_pin_o)
    else $error("square wave pin not low while disabled");

  chk_halt_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ctrl_i.time_halt && (ctrl_i.square_wave_pin_rate_select >= `RTCTO_SEL_4K) &&
     (ctrl_i.square_wave_pin_rate_select <= `RTCTO_SEL_1HZ)) |=> !square_wave_pin_o)
    else $error("stoppable rate still toggling during halt");

  chk_fast_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ctrl_i.square_wave_output_enable && (ctrl_i.square_wave_pin_rate_select == `RTCTO_SEL_16K)) |=>
    (square_wave_pin_o == $past(stage[0])))
    else $error("16 kHz output not following its tap");

endmodule : rtcto_trim_square_wave_pin

/* File: test_rtcto_trim_square_wave_pin.sv */
// Purpose: self-checking bench for the trim scheduler and square wave output
// Assumes: oscillator made here with two clk per phase, control bits driven as plain ports
// Notes:   a trimmed second is too long for a full trim cycle; trim values stay random meanwhile
`timescale 1ns/10ps
`include "rtcto_defines.svh"
module test_rtcto_trim_square_wave_pin
  import rtcto_pkg::*;
;
  logic        clk_i     = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        osc_32k_i = 1'b0;
  rtcto_ctrl_t ctrl_i    = '0;
  logic        square_wave_pin_o;
  logic        trim_irq_n_o;
  logic        second_tick_o;
  logic        timer_64hz_o;
  int          errors      = 0;
  int          checks_done = 0;
  int          irq_low_cnt = 0;
  int          osc_div     = 0;
  logic [31:0] lfsr_state  = 32'hA55D5932;

  rtcto_trim_square_wave_pin DUT (
    .clk_i             (clk_i),
    .rst_n_i           (rst_n_i),
    .osc_32k_i         (osc_32k_i),
    .ctrl_i            (ctrl_i),
    .square_wave_pin_o (square_wave_pin_o),
    .trim_irq_n_o      (trim_irq_n_o),
    .second_tick_o     (second_tick_o),
    .timer_64hz_o      (timer_64hz_o)
  );

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  // oscillator: four clk per period, changed off the sampling edge
  always @(negedge clk_i) begin
    osc_div   <= osc_div + 1;
    osc_32k_i <= osc_div[1];
    if (rst_n_i && trim_irq_n_o !== 1'b1) irq_low_cnt <= irq_low_cnt + 1;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // half period in clk of a divided tap: osc period 4 clk, code c divides by 2^c
  function automatic logic [31:0] exp_half(input logic [2:0] c);
    return 32'h2 << c;
  endfunction : exp_half

  // interrupt low cycles owed by the tick into second 1 of minute 0:
  // one step when the magnitude reaches two, low for one osc period (4 clk)
  function automatic logic [31:0] exp_irq_low(input logic [6:0] v, input logic fast, input logic en);
    int m;
    m = v[6] ? (128 - int'(v)) : int'(v);
    return (fast && en && (m >= 2)) ? 32'h4 : 32'h0;
  endfunction : exp_irq_low

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic compare(input logic [31:0] seen, input logic [31:0] expect_v);
    checks_done++;
    if (seen !== expect_v) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, expect_v);
    end
  endtask : compare

  // random trim fields each time; they must never disturb the fast taps
  task automatic set_ctrl(input logic [2:0] code, input logic halt, input logic en);
    lfsr_state = lfsr_next(lfsr_state);
    ctrl_i.trim_fast                 = lfsr_state[7];
    ctrl_i.trim_value                = lfsr_state[6:0];
    ctrl_i.trim_irq_enable           = lfsr_state[8];
    ctrl_i.square_wave_pin_rate_select        = code;
    ctrl_i.square_wave_output_enable = en;
    ctrl_i.time_halt                 = halt;
  endtask : set_ctrl

  // bounded wait on the pin or the 64 Hz tap; a hang ends the run
  task automatic wait_for(input bit use_t, input logic val, output int n);
    n = 0;
    while (((use_t ? timer_64hz_o : square_wave_pin_o) !== val) && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 5000) begin
      errors++;
      $display("ERROR at %0t: wait ran out, seen %h expected %h", $time, !val, val);
      tally_and_finish();
    end
  endtask : wait_for

  task automatic measure(input bit use_t, output int hi, output int lo);
    int n;
    // let a new select reach the pin so no partial phase is measured
    repeat (2) @(negedge clk_i);
    wait_for(use_t, 1'b0, n);
    wait_for(use_t, 1'b1, n);
    wait_for(use_t, 1'b0, hi);
    wait_for(use_t, 1'b1, lo);
  endtask : measure

  // high cycles of the pin and of the 64 Hz tap over a span
  task automatic count_high(input int span, output int p, output int t);
    p = 0;
    t = 0;
    repeat (span) begin
      @(negedge clk_i);
      if (square_wave_pin_o !== 1'b0) p++;
      if (timer_64hz_o !== 1'b0) t++;
    end
  endtask : count_high

  initial begin
    int hi;
    int lo;
    int p;
    int t;
    int n;
    ctrl_i.square_wave_output_enable = 1'b1;
    // reset held ten cycles; outputs checked while it is held
    repeat (5) @(negedge clk_i);
    compare(square_wave_pin_o, 1'b0);
    compare(trim_irq_n_o, 1'b1);
    compare({second_tick_o, timer_64hz_o}, 2'h0);
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    $display("test reset done");

    // every selectable fast rate, default code first with no software action
    for (int c = 0; c < 6; c++) begin
      if (c > 0) set_ctrl(c[2:0], 1'b0, 1'b1);
      measure(1'b0, hi, lo);
      if (c == 0) begin
        compare(hi + lo, 32'h4);
      end else begin
        compare(hi, exp_half(c[2:0]));
        compare(lo, exp_half(c[2:0]));
      end
    end
    $display("test rates done");

    // 64 Hz timer tap: 512 osc periods, even halves
    measure(1'b1, hi, lo);
    compare(hi, 32'h400);
    compare(lo, 32'h400);
    $display("test timer tap done");

    // off code and cleared enable both give a steady low
    set_ctrl(`RTCTO_SEL_OFF, 1'b0, 1'b1);
    @(negedge clk_i);
    count_high(200, p, t);
    compare(p, 32'h0);
    set_ctrl(`RTCTO_SEL_16K, 1'b0, 1'b0);
    @(negedge clk_i);
    count_high(200, p, t);
    compare(p, 32'h0);
    $display("test disable done");

    // halt: low codes keep toggling, the rest stay low, upper prescaler frozen
    for (int c = 0; c < 8; c++) begin
      set_ctrl(c[2:0], 1'b1, 1'b1);
      repeat (4) @(negedge clk_i);
      count_high(100, p, t);
      compare(p != 0, c <= 2);
      compare(t, 32'h0);
    end
    $display("test halt done");

    // release halt on the 1 Hz code: first tick about 16384 osc periods later;
    // fast trim with interrupt on and the most negative value as a corner
    set_ctrl(`RTCTO_SEL_1HZ, 1'b0, 1'b1);
    ctrl_i.trim_fast       = 1'b1;
    ctrl_i.trim_irq_enable = 1'b1;
    ctrl_i.trim_value      = 7'h40;
    n = 0;
    p = 0;
    while (second_tick_o !== 1'b1 && n < 70000) begin
      @(negedge clk_i);
      n++;
      if (n < 65000 && square_wave_pin_o !== 1'b0) p++;
    end
    compare(n >= 65500 && n <= 65560, 1'b1);
    compare(p, 32'h0);
    repeat (4) @(negedge clk_i);
    compare(square_wave_pin_o, 1'b1);
    compare(irq_low_cnt, 32'h0);
    // the step owed for second 1 lands on the next low-stage carry
    repeat (200) @(negedge clk_i);
    compare(irq_low_cnt, exp_irq_low(ctrl_i.trim_value, ctrl_i.trim_fast, ctrl_i.trim_irq_enable));
    $display("test second tick done");
    tally_and_finish();
  end
endmodule : test_rtcto_trim_square_wave_pin
